// *** src/pfs_ffa_accum.sv ***
`timescale 1ns/1ps
`default_nettype none
// Fraction accumulator: adds the fraction on each step while active, flags the carry.
module pfs_ffa_accum #(
  parameter int FFA_W = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  pfs_ffa_if.accum ffa
);
  // =========================================================
  // State
  typedef struct packed {
    logic [FFA_W-1:0] acc;
  } pfs_acc_state_t;
  pfs_acc_state_t s_q;
  pfs_acc_state_t s_d;
  logic [FFA_W:0] sum; // Sum with the carry in its top bit.

  // The carry is combinational so the engine can latch it with the event.
  always_comb
  begin
    sum = {1'b0, s_q.acc} + {1'b0, ffa.frac};
    s_d = s_q;
    if (ffa.step && ffa.active)
    begin
      s_d.acc = sum[FFA_W-1:0]; // RULE1
    end
    else if (!ffa.active)
    begin
      // Leaving the fixed modes drops the residue so a restart is clean.
      s_d.acc = '0;
    end
  end

  // Register the accumulator.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ffa.carry = ffa.active & sum[FFA_W]; // RULE2
  assign ffa.acc = s_q.acc;
endmodule
`default_nettype wire

// *** src/pfs_ffa_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Link between the period engine and the fraction accumulator.
interface pfs_ffa_if #(parameter int FFA_W = 4);
  logic step;
  logic active;
  logic [FFA_W-1:0] frac;
  logic carry;
  logic [FFA_W-1:0] acc;
  modport engine (output step, output active, output frac,
    input carry, input acc);
  modport accum (input step, input active, input frac,
    output carry, output acc);
endinterface
`default_nettype wire

// *** src/pfs_map.svh ***
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
// Register indices on the plain register port.
`define PFS_ADDR_SYNC 3'h0
`define PFS_ADDR_PERIOD 3'h1
`define PFS_ADDR_FRAC 3'h2
`define PFS_ADDR_CTRL 3'h3
`define PFS_ADDR_STATUS 3'h4
`define PFS_ADDR_PHASE 3'h5
`define PFS_ADDR_DUTY 3'h6
// Fields of period_sync_control.
`define PFS_SYNC_POFST_BIT 7
`define PFS_SYNC_PRPOL_BIT 6
`define PFS_SYNC_DCPOL_BIT 5
`define PFS_SYNC_SEL_HI 1
`define PFS_SYNC_SEL_LO 0
`define PFS_SYNC_WMASK 8'he3
`define PFS_SYNC_RESET 8'h00
// Sync source select codes.
`define PFS_SEL_OWN 2'h0
`define PFS_SEL_RSVD 2'h1
`define PFS_SEL_SIB_B 2'h2
`define PFS_SEL_SIB_C 2'h3
// Fields of the control register.
`define PFS_CTRL_EN_BIT 0
`define PFS_CTRL_MODE_HI 2
`define PFS_CTRL_MODE_LO 1
`define PFS_CTRL_EXTP_BIT 3
`define PFS_CTRL_EXTD_BIT 4
`define PFS_CTRL_FFA_BIT 5
`define PFS_CTRL_RESET 6'h00
// Reset values of the count registers.
`define PFS_PERIOD_RESET 16'h00ff
`define PFS_PHASE_RESET 16'h0000
`define PFS_DUTY_RESET 16'h0080
`endif

// *** src/pfs_pkg.sv ***
package pfs_pkg;
  // Operating modes held in the control register.
  typedef enum logic [1:0] {
    PFS_MODE_NORMAL = 2'h0,
    PFS_MODE_FIXED = 2'h1,
    PFS_MODE_FIXED_COMP = 2'h2,
    PFS_MODE_NORMAL_COMP = 2'h3
  } pfs_mode_t;
  // Output latch state, one-hot.
  typedef enum logic [2:0] {
    PFS_OUT_IDLE = 3'b001,
    PFS_OUT_ON = 3'b010,
    PFS_OUT_OFF = 3'b100
  } pfs_out_t;
endpackage

// *** src/pfs_top.sv ***
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
// Function
// RULE1 - Add fraction to accumulator each period event
// RULE2 - Carry lengthens next period by one clock
// RULE3 - Fraction acts only in fixed duty modes
// RULE4 - Fixed duty period is two period events
// RULE5 - Fraction step is clock over two-power-width
// RULE6 - Phase offset bit swaps sync and latch sources
// RULE7 - Period invert bit inverts external period input
// RULE8 - Duty invert bit inverts external duty input
// RULE9 - Sync select: own, sibling B, sibling C
module pfs_top
  import pfs_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int FFA_W = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic period_evt_pin,
  input wire logic duty_evt_pin,
  input wire logic sync_in_b,
  input wire logic sync_in_c,
  output logic sync_out,
  output logic period_event,
  output logic pwm_a,
  output logic pwm_b
);
  // =========================================================
  // Reset release
  logic [1:0] rst_sync_q; // Two-stage release of the async reset.
  logic rst_n; // Synchronised reset used by all other logic.

  // The reset asserts at once and leaves two edges after nrst rises.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // =========================================================
  // State
  typedef struct packed {
    logic [7:0] sync_ctl; // period_sync_control.
    logic [5:0] ctrl; // Enable, mode, input enables, fraction enable.
    logic [CNT_W-1:0] period; // period_count_value.
    logic [CNT_W-1:0] phase; // Phase event count.
    logic [CNT_W-1:0] duty; // Duty event count.
    logic [FFA_W-1:0] frac; // fraction_increment_value.
    logic [CNT_W-1:0] cnt; // Running period counter.
    logic stretch; // Current period is one clock longer.
    logic [2:0] out_st; // Output latch state.
    logic pin_p1; // Period pin, first stage.
    logic pin_p2; // Period pin, second stage.
    logic pin_p3; // Period pin, previous value for edges.
    logic pin_d1; // Duty pin, first stage.
    logic pin_d2; // Duty pin, second stage.
    logic pin_d3; // Duty pin, previous value for edges.
    logic sync_out; // Registered sync output.
    logic per_evt; // Registered period event pulse.
    logic pwm_a; // Registered primary output.
    logic pwm_b; // Registered complementary output.
    logic [15:0] rdata; // Read data, valid one cycle after the strobe.
  } pfs_state_t;

  pfs_state_t s_q;
  pfs_state_t s_d;

  pfs_ffa_if #(.FFA_W(FFA_W)) ffa ();

  // Decoded views of the control registers.
  logic enable;
  pfs_mode_t mode;
  logic fixed_mode;
  logic comp_mode;
  logic [1:0] sync_sel;
  logic pofst;
  logic prpol;
  logic dcpol;
  // Events inside one period.
  logic [CNT_W:0] tc_value;
  logic tc;
  logic sel_evt;
  logic ext_p;
  logic ext_d;
  logic per_evt;
  logic phase_evt;
  logic duty_evt;
  logic latch_set;
  logic [2:0] next_st;

  // =========================================================
  // Field decode
  always_comb
  begin
    enable = s_q.ctrl[`PFS_CTRL_EN_BIT];
    mode = pfs_mode_t'(s_q.ctrl[`PFS_CTRL_MODE_HI:`PFS_CTRL_MODE_LO]);
    fixed_mode = (mode == PFS_MODE_FIXED) || (mode == PFS_MODE_FIXED_COMP);
    comp_mode = (mode == PFS_MODE_FIXED_COMP) ||
      (mode == PFS_MODE_NORMAL_COMP);
    sync_sel = s_q.sync_ctl[`PFS_SYNC_SEL_HI:`PFS_SYNC_SEL_LO];
    pofst = s_q.sync_ctl[`PFS_SYNC_POFST_BIT];
    prpol = s_q.sync_ctl[`PFS_SYNC_PRPOL_BIT];
    dcpol = s_q.sync_ctl[`PFS_SYNC_DCPOL_BIT];
  end

  // The fraction only reaches the period in the fixed duty modes.
  assign ffa.active = enable & s_q.ctrl[`PFS_CTRL_FFA_BIT] &
    fixed_mode; // RULE3
  assign ffa.frac = s_q.frac;
  assign ffa.step = per_evt;

  // =========================================================
  // Period engine and event sources
  always_comb
  begin
    // A carry stretches by one clock; with FFA_W bits the average step is
    // one clock divided by two to the FFA_W.
    tc_value = {1'b0, s_q.period} +
      {{CNT_W{1'b0}}, s_q.stretch}; // RULE2 RULE5
    tc = enable && ({1'b0, s_q.cnt} == tc_value);
    // Sibling sync outputs share this clock, so they need no synchroniser.
    if (sync_sel == `PFS_SEL_SIB_B)
    begin
      sel_evt = enable & sync_in_b; // RULE9
    end
    else if (sync_sel == `PFS_SEL_SIB_C)
    begin
      sel_evt = enable & sync_in_c; // RULE9
    end
    else
    begin
      // Own period event; the reserved code behaves the same.
      sel_evt = tc; // RULE9
    end
    // Edges are taken after the polarity choice, so inverting picks the
    // falling pin edge.
    ext_p = enable && s_q.ctrl[`PFS_CTRL_EXTP_BIT] &&
      ((s_q.pin_p2 ^ prpol) && !(s_q.pin_p3 ^ prpol)); // RULE7
    ext_d = enable && s_q.ctrl[`PFS_CTRL_EXTD_BIT] &&
      ((s_q.pin_d2 ^ dcpol) && !(s_q.pin_d3 ^ dcpol)); // RULE8
    per_evt = sel_evt | ext_p;
    phase_evt = enable && (s_q.cnt == s_q.phase);
    duty_evt = (enable && (s_q.cnt == s_q.duty)) | ext_d;
    latch_set = pofst ? per_evt : phase_evt; // RULE6
  end

  // =========================================================
  // Output latch
  always_comb
  begin
    next_st = s_q.out_st;
    case (s_q.out_st)
      PFS_OUT_IDLE:
      begin
        if (enable)
          next_st = PFS_OUT_OFF;
      end
      PFS_OUT_ON:
      begin
        if (!enable)
          next_st = PFS_OUT_IDLE;
        else if (fixed_mode && per_evt)
          next_st = PFS_OUT_OFF; // RULE4
        else if (!fixed_mode && duty_evt && !latch_set)
          next_st = PFS_OUT_OFF;
      end
      PFS_OUT_OFF:
      begin
        if (!enable)
          next_st = PFS_OUT_IDLE;
        else if (fixed_mode && per_evt)
          next_st = PFS_OUT_ON; // RULE4
        else if (!fixed_mode && latch_set)
          next_st = PFS_OUT_ON; // RULE6
      end
      default:
      begin
        next_st = PFS_OUT_IDLE;
      end
    endcase
  end

  // =========================================================
  // Next state, register port included
  always_comb
  begin
    s_d = s_q;
    // Pin synchronisers; the first stage feeds only the second.
    s_d.pin_p1 = period_evt_pin;
    s_d.pin_p2 = s_q.pin_p1;
    s_d.pin_p3 = s_q.pin_p2;
    s_d.pin_d1 = duty_evt_pin;
    s_d.pin_d2 = s_q.pin_d1;
    s_d.pin_d3 = s_q.pin_d2;
    // Counter restarts on a period event or at its own terminal count,
    // so a missing sibling sync never lets it run past the period.
    if (!enable)
    begin
      s_d.cnt = '0;
      s_d.stretch = 1'b0;
    end
    else if (per_evt)
    begin
      s_d.cnt = '0;
      s_d.stretch = ffa.carry; // RULE1 RULE2
    end
    else if (tc)
    begin
      s_d.cnt = '0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    s_d.out_st = next_st;
    s_d.pwm_a = (next_st == PFS_OUT_ON);
    s_d.pwm_b = comp_mode && (next_st == PFS_OUT_OFF);
    s_d.sync_out = pofst ? phase_evt : per_evt; // RULE6
    s_d.per_evt = per_evt;
    // Register writes.
    if (reg_wr)
    begin
      if (reg_addr == `PFS_ADDR_SYNC)
        s_d.sync_ctl = reg_wdata[7:0] & `PFS_SYNC_WMASK;
      else if (reg_addr == `PFS_ADDR_PERIOD)
        s_d.period = reg_wdata[CNT_W-1:0];
      else if (reg_addr == `PFS_ADDR_FRAC)
        s_d.frac = reg_wdata[FFA_W-1:0];
      else if (reg_addr == `PFS_ADDR_CTRL)
        s_d.ctrl = reg_wdata[5:0];
      else if (reg_addr == `PFS_ADDR_PHASE)
        s_d.phase = reg_wdata[CNT_W-1:0];
      else if (reg_addr == `PFS_ADDR_DUTY)
        s_d.duty = reg_wdata[CNT_W-1:0];
    end
    // Read data stands for one cycle only; unmapped indices read zero.
    s_d.rdata = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == `PFS_ADDR_SYNC)
        s_d.rdata = {8'h00, s_q.sync_ctl};
      else if (reg_addr == `PFS_ADDR_PERIOD)
        s_d.rdata = 16'(s_q.period);
      else if (reg_addr == `PFS_ADDR_FRAC)
        s_d.rdata = 16'(s_q.frac);
      else if (reg_addr == `PFS_ADDR_CTRL)
        s_d.rdata = {10'h000, s_q.ctrl};
      else if (reg_addr == `PFS_ADDR_STATUS)
        s_d.rdata = {8'h00, 4'(ffa.acc), 1'b0, ffa.active, s_q.stretch,
          s_q.pwm_a};
      else if (reg_addr == `PFS_ADDR_PHASE)
        s_d.rdata = 16'(s_q.phase);
      else if (reg_addr == `PFS_ADDR_DUTY)
        s_d.rdata = 16'(s_q.duty);
    end
  end

  // =========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.sync_ctl <= `PFS_SYNC_RESET;
      s_q.ctrl <= `PFS_CTRL_RESET;
      s_q.period <= CNT_W'(`PFS_PERIOD_RESET);
      s_q.phase <= CNT_W'(`PFS_PHASE_RESET);
      s_q.duty <= CNT_W'(`PFS_DUTY_RESET);
      s_q.out_st <= PFS_OUT_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // Fraction accumulator
  pfs_ffa_accum #(
    .FFA_W(FFA_W)
  ) u_accum (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ffa(ffa)
  );

  assign reg_rdata = s_q.rdata;
  assign sync_out = s_q.sync_out;
  assign period_event = s_q.per_evt;
  assign pwm_a = s_q.pwm_a;
  assign pwm_b = s_q.pwm_b;
endmodule
`default_nettype wire

// *** tb/pfs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port-side checker: mirrors the sync, control and period writes and watches the event outputs.
module pfs_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic period_evt_pin,
  input wire logic duty_evt_pin,
  input wire logic sync_in_b,
  input wire logic sync_in_c,
  input wire logic sync_out,
  input wire logic period_event,
  input wire logic pwm_a,
  input wire logic pwm_b
);
  logic [7:0] sy_q; // Shadow of the sync control register.
  logic [5:0] ct_q; // Shadow of the control register.
  logic [15:0] pr_q; // Shadow of the period count.
  logic [16:0] gap_q; // Cycles since the last period event.
  logic [1:0] w_q; // Events left before a write has settled.
  wire logic fix = (ct_q[2:1] == 2'h1) || (ct_q[2:1] == 2'h2);
  wire logic calm = (w_q == 2'h0) && ct_q[0] && !ct_q[3] && !sy_q[1];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========
  // Shadow state; a write holds off gap checks for the next two period events,
  // because the period in flight was set up under the old values.
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      sy_q <= 8'h00;
      ct_q <= 6'h00;
      pr_q <= 16'h00ff;
      gap_q <= 17'h00000;
      w_q <= 2'h0;
    end
    else
    begin
      gap_q <= period_event ? 17'h00000 : gap_q + 17'h00001;
      if (reg_wr)
        w_q <= 2'h2;
      else if (period_event && (w_q != 2'h0))
        w_q <= w_q - 2'h1;
      if (reg_wr && (reg_addr == 3'h0))
        sy_q <= reg_wdata[7:0] & 8'he3;
      if (reg_wr && (reg_addr == 3'h3))
        ct_q <= reg_wdata[5:0];
      if (reg_wr && (reg_addr == 3'h1))
        pr_q <= reg_wdata;
    end
  sync_source_a: assert property (
    !sy_q[7] && $stable(sy_q) |-> sync_out == period_event)
    else $error("sync_out not on period event");
  fixed_toggle_a: assert property (
    fix && ct_q[0] && $stable(ct_q)
    |-> (pwm_a != $past(pwm_a)) == period_event)
    else $error("pwm_a toggle not tied to period event");
  plain_gap_a: assert property (
    calm && !(fix && ct_q[5]) && period_event |-> gap_q == {1'b0, pr_q})
    else $error("period length changed without fraction");
  stretch_gap_a: assert property (
    calm && fix && ct_q[5] && period_event
    |-> (gap_q - {1'b0, pr_q}) <= 17'h00001)
    else $error("stretched period not one clock");
  off_quiet_a: assert property (
    !ct_q[0] && !$past(ct_q[0])
    |-> !period_event && !pwm_a && !pwm_b && !sync_out)
    else $error("outputs active while disabled");
  comp_idle_a: assert property (
    !ct_q[2] && $stable(ct_q) |-> !pwm_b)
    else $error("pwm_b active outside complementary modes");
  sib_b_follow_a: assert property (
    ct_q[0] && (sy_q[1:0] == 2'h2) && $stable(sy_q) && sync_in_b
    |=> period_event)
    else $error("sibling b sync ignored");
  sib_c_follow_a: assert property (
    ct_q[0] && (sy_q[1:0] == 2'h3) && $stable(sy_q) && sync_in_c
    |=> period_event)
    else $error("sibling c sync ignored");
  ext_period_a: assert property (
    ct_q[0] && ct_q[3] && $stable(sy_q) && $changed(period_evt_pin)
    && (period_evt_pin != sy_q[6]) |-> ##[1:6] period_event)
    else $error("external period edge lost");
endmodule
bind pfs_top pfs_checker chk (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_evt_pin(period_evt_pin),
  .duty_evt_pin(duty_evt_pin), .sync_in_b(sync_in_b),
  .sync_in_c(sync_in_c), .sync_out(sync_out),
  .period_event(period_event), .pwm_a(pwm_a), .pwm_b(pwm_b));
`default_nettype wire

// *** tb/pfs_sibling.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Sibling module stand-in: one sync pulse every GAP kernel clocks.
module pfs_sibling #(
  parameter int GAP = 7
) (
  input wire logic clk_sys,
  input wire logic nrst,
  output logic sync_pulse
);
  int cnt_q; // Position within the sibling's own period.
  // Free-running; a short GAP answers promptly, a long one slowly.
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      cnt_q <= 0;
      sync_pulse <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      sync_pulse <= (cnt_q == GAP - 1);
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic pin_p = 1'b0; // External period event pin.
  logic pin_d = 1'b0; // External duty event pin.
  logic sib_b, sib_c, sync_out, pev, pwm_a, pwm_b;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  pfs_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .period_evt_pin(pin_p), .duty_evt_pin(pin_d),
    .sync_in_b(sib_b), .sync_in_c(sib_c), .sync_out(sync_out),
    .period_event(pev), .pwm_a(pwm_a), .pwm_b(pwm_b));
  pfs_sibling #(.GAP(7)) sib0 (.clk_sys(clk_sys), .nrst(nrst),
    .sync_pulse(sib_b));
  pfs_sibling #(.GAP(11)) sib1 (.clk_sys(clk_sys), .nrst(nrst),
    .sync_pulse(sib_c));
  // ==========
  // Access tasks and the single compare.
  task automatic check(input string what, input logic [16:0] e,
    input logic [16:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe is taken.
  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    check("register", {1'b0, e}, {1'b0, reg_rdata});
  endtask
  // Cycles taken by n period events, measured from one event.
  task automatic span(input int n, output int cyc);
    int k;
    k = 0;
    cyc = 0;
    do @(posedge clk_sys); while (pev !== 1'b1);
    while (k < n)
    begin
      @(posedge clk_sys);
      cyc++;
      if (pev === 1'b1)
        k++;
    end
  endtask
  task automatic cnt(output int k);
    k = 0;
    repeat (8)
    begin
      @(posedge clk_sys);
      if (pev === 1'b1)
        k++;
    end
  endtask
  task automatic test_done();
    $display("TB: %0d comparisons, %0d miscompares", comparisons,
      miscompares);
    if ((miscompares == 0) && (comparisons > 0))
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // Test sequence.
  initial
  begin
    int fr[3] = '{1, 8, 15};
    int c;
    logic p;
    logic pa;
    logic [1:0] q;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rc(`PFS_ADDR_SYNC, 16'h0000);
    rc(`PFS_ADDR_PERIOD, 16'h00ff);
    wr(`PFS_ADDR_SYNC, 16'h00ff);
    rc(`PFS_ADDR_SYNC, 16'h00e3);
    rc(3'h7, 16'h0000);
    $display("TB: register test done");
    // Sixteen adds of a 4-bit fraction f carry exactly f times.
    wr(`PFS_ADDR_SYNC, 16'h0000);
    wr(`PFS_ADDR_PERIOD, 16'h0003);
    for (int m = 0; m < 4; m++)
      foreach (fr[i])
      begin
        wr(`PFS_ADDR_FRAC, fr[i][15:0]);
        wr(`PFS_ADDR_CTRL, {10'h000, 3'h4, m[1:0], 1'b1});
        span(16, c);
        check("span", 17'(64 + (m % 3 ? fr[i] : 0)), c[16:0]);
      end
    $display("TB: fraction test done");
    wr(`PFS_ADDR_PERIOD, 16'h00ff);
    wr(`PFS_ADDR_CTRL, 16'h0003);
    for (int s = 2; s < 4; s++)
    begin
      wr(`PFS_ADDR_SYNC, s[15:0]);
      repeat (4) @(posedge clk_sys);
      // Seed the one-cycle history from what stands now.
      p = (s == 2) ? sib_b : sib_c;
      pa = pwm_a;
      repeat (40)
      begin
        @(posedge clk_sys);
        check("sib event", {16'h0, p}, {16'h0, pev});
        check("sync out", {16'h0, pev}, {16'h0, sync_out});
        check("pwm toggle", {16'h0, pev}, {16'h0, pwm_a ^ pa});
        p = (s == 2) ? sib_b : sib_c;
        pa = pwm_a;
      end
    end
    $display("TB: sibling test done");
    wr(`PFS_ADDR_PERIOD, 16'hffff);
    wr(`PFS_ADDR_CTRL, 16'h0009);
    for (int v = 0; v < 2; v++)
    begin
      wr(`PFS_ADDR_SYNC, {9'h000, v[0], 6'h00});
      // Let a sibling pulse taken under the old select drain first.
      @(posedge clk_sys);
      pin_p <= v[0];
      cnt(c);
      check("idle edge", 17'h0, c[16:0]);
      pin_p <= !v[0];
      cnt(c);
      check("active edge", 17'h1, c[16:0]);
      pin_p <= v[0];
      cnt(c);
      check("back edge", 17'h0, c[16:0]);
    end
    $display("TB: pin test done");
    // Offset bit set: sync_out carries the phase event, two cycles after the period event.
    wr(`PFS_ADDR_CTRL, 16'h0000);
    wr(`PFS_ADDR_SYNC, 16'h0080);
    wr(`PFS_ADDR_PHASE, 16'h0001);
    wr(`PFS_ADDR_PERIOD, 16'h0003);
    wr(`PFS_ADDR_CTRL, 16'h0001);
    q = 2'b00;
    for (int j = 0; j < 26; j++)
    begin
      @(posedge clk_sys);
      if (j > 3)
        check("phase sync", {16'h0, q[1]}, {16'h0, sync_out});
      q = {q[0], pev};
    end
    $display("TB: phase test done");
    // Normal mode: phase event sets the output, a duty pin edge ends it.
    wr(`PFS_ADDR_PHASE, 16'h0002);
    wr(`PFS_ADDR_DUTY, 16'hffff);
    wr(`PFS_ADDR_PERIOD, 16'hffff);
    for (int v = 0; v < 2; v++)
    begin
      wr(`PFS_ADDR_CTRL, 16'h0000);
      wr(`PFS_ADDR_SYNC, {10'h000, v[0], 5'h00});
      pin_d <= !v[0];
      repeat (4) @(posedge clk_sys);
      wr(`PFS_ADDR_CTRL, 16'h0011);
      repeat (6) @(posedge clk_sys);
      check("duty on", 17'h1, {16'h0, pwm_a});
      pin_d <= v[0];
      repeat (6) @(posedge clk_sys);
      check("idle duty edge", 17'h1, {16'h0, pwm_a});
      pin_d <= !v[0];
      repeat (6) @(posedge clk_sys);
      check("duty edge", 17'h0, {16'h0, pwm_a});
    end
    $display("TB: duty test done");
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
